/* bench/group_link_checker.sv */
// link checker: slot ownership and frame framing on the shared line
`timescale 1ns/1ps
module group_link_checker #(
  parameter logic [21:0] SLOT_P = 22'(group_pkg::SLOT_CYCLES)
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [group_pkg::FRAME_W-1:0] dev_data,
  input wire logic dev_oe_n,
  input wire logic [group_pkg::FRAME_W-1:0] peer_data,
  input wire logic peer_oe_n,
  input wire logic [group_pkg::FRAME_W-1:0] line
);
  logic [21:0] dev_cnt;
  logic [21:0] peer_cnt;
  logic [7:0] since_rst;

  // drive lengths counted here, too long for a repetition
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dev_cnt <= '0;
      peer_cnt <= '0;
      since_rst <= '0;
    end
    else
    begin
      dev_cnt <= dev_oe_n ? '0 : dev_cnt + 22'h000001;
      peer_cnt <= peer_oe_n ? '0 : peer_cnt + 22'h000001;
      since_rst <= (since_rst == 8'hFF) ? since_rst : since_rst + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_one_talker;
    !(!dev_oe_n && !peer_oe_n);
  endproperty
  a_one_talker: assert property (p_one_talker)
    else $error("both ends drive the line");

  property p_dev_valid;
    !dev_oe_n |-> dev_data[group_pkg::F_VALID];
  endproperty
  a_dev_valid: assert property (p_dev_valid)
    else $error("device frame without valid bit");

  property p_peer_valid;
    !peer_oe_n |-> peer_data[group_pkg::F_VALID];
  endproperty
  a_peer_valid: assert property (p_peer_valid)
    else $error("peer frame without valid bit");

  property p_dev_stands;
    !dev_oe_n && !$past(dev_oe_n) |-> $stable(dev_data);
  endproperty
  a_dev_stands: assert property (p_dev_stands)
    else $error("device frame changed inside its slot");

  property p_dev_slot_len;
    $rose(dev_oe_n) |-> dev_cnt == SLOT_P;
  endproperty
  a_dev_slot_len: assert property (p_dev_slot_len)
    else $error("device drive length differs from slot");

  property p_peer_slot_len;
    $rose(peer_oe_n) |-> peer_cnt == SLOT_P;
  endproperty
  a_peer_slot_len: assert property (p_peer_slot_len)
    else $error("peer drive length differs from slot");

  property p_dev_group;
    !dev_oe_n |-> dev_data[7:3] <= group_pkg::GROUP_MAX;
  endproperty
  a_dev_group: assert property (p_dev_group)
    else $error("device sent a group above the limit");

  property p_dev_addr_first;
    since_rst == 8'h04 |-> !dev_oe_n && dev_data[12:8] == 5'h00;
  endproperty
  a_dev_addr_first: assert property (p_dev_addr_first)
    else $error("reset address does not own the first slot");

  property p_discover_order;
    since_rst < 8'h65 |-> peer_oe_n;
  endproperty
  a_discover_order: assert property (p_discover_order)
    else $error("peer talked outside its discovery slot");

  property p_dev_line;
    !dev_oe_n |-> line == dev_data;
  endproperty
  a_dev_line: assert property (p_dev_line)
    else $error("line differs from device frame in its slot");
endmodule

/* bench/test_group_run_stop_arbiter.sv */
// self-checking bench: both link ends, run/stop, contact and editor cases
`timescale 1ns/1ps
module test_group_run_stop_arbiter;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] protocol = 4'h2;
  logic fitted = 1'b0;
  logic contact_assign = 1'b0;
  logic contact = 1'b1;
  logic run_req = 1'b0;
  logic stop_req = 1'b0;
  logic edit_key = 1'b0;
  logic edit_target = 1'b0;
  logic [4:0] edit_value = 5'h00;
  logic edit_set = 1'b0;
  logic p_run = 1'b0;
  logic p_stop = 1'b0;
  logic [4:0] p_group = 5'h03;
  logic n_running;
  group_pkg::stop_code_type n_code;
  logic [4:0] n_addr;
  logic [4:0] n_group;
  logic n_edit;
  logic [31:0] n_present;
  logic p_running;
  logic p_gstop;
  int mismatches = 0;
  int checked = 0;

  group_link_if group_link_if_inst ();
  // short slot and edit timeout keep the run brief; both ends must agree
  group_node #(.SLOT_P(22'd20), .EDIT_P(32'd50)) group_node_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .link(group_link_if_inst), .protocol_in(protocol),
    .contact_fitted_in(fitted), .contact_assign_in(contact_assign),
    .contact_input_in(contact), .run_req_in(run_req),
    .stop_req_in(stop_req), .edit_key_in(edit_key),
    .edit_target_in(edit_target), .edit_value_in(edit_value),
    .edit_set_in(edit_set), .running_out(n_running),
    .stop_code_out(n_code), .dev_addr_out(n_addr), .group_out(n_group),
    .editing_out(n_edit), .present_out(n_present));
  group_peer #(.SLOT_P(22'd20)) group_peer_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .link(group_link_if_inst), .addr_in(5'h05), .group_in(p_group),
    .run_req_in(p_run), .stop_req_in(p_stop),
    .running_out(p_running), .group_stop_out(p_gstop));
  group_link_checker #(.SLOT_P(22'd20)) group_link_checker_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .dev_data(group_link_if_inst.dev_data),
    .dev_oe_n(group_link_if_inst.dev_oe_n),
    .peer_data(group_link_if_inst.peer_data),
    .peer_oe_n(group_link_if_inst.peer_oe_n),
    .line(group_link_if_inst.line));

  initial
  begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic end_sim;
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic do_reset;
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    cyc(1);
  endtask

  // outputs settle one edge after the pulse is taken
  task automatic node_cmd(input logic run);
    @(posedge ref_clk_in);
    run_req <= run;
    stop_req <= !run;
    @(posedge ref_clk_in);
    run_req <= 1'b0;
    stop_req <= 1'b0;
    cyc(2);
  endtask

  task automatic peer_cmd(input logic run);
    @(posedge ref_clk_in);
    p_run <= run;
    p_stop <= !run;
    @(posedge ref_clk_in);
    p_run <= 1'b0;
    p_stop <= 1'b0;
    cyc(2);
  endtask

  task automatic edit(input logic t, input logic [4:0] v, input logic s);
    @(posedge ref_clk_in);
    edit_key <= 1'b1;
    edit_target <= t;
    edit_value <= v;
    @(posedge ref_clk_in);
    edit_key <= 1'b0;
    if (s)
    begin
      @(posedge ref_clk_in);
      edit_set <= 1'b1;
      @(posedge ref_clk_in);
      edit_set <= 1'b0;
    end
    cyc(1);
  endtask

  // bounded wait: two slots of lag plus margin
  task automatic wait_run(input logic peer, input logic exp);
    repeat (200)
      if ((peer ? p_running : n_running) !== exp)
        cyc(1);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    end_sim();
  end

  initial
  begin
    do_reset();
    check(n_running, 1'b0);
    check(n_code, group_pkg::CODE_STOP);
    check(n_addr, 5'h00);
    check(n_group, 5'h00);
    edit(1'b0, 5'h11, 1'b1);
    check(n_group, 5'h00);
    edit(1'b0, 5'h03, 1'b1);
    check(n_group, 5'h03);
    edit(1'b1, 5'h1F, 1'b0);
    check(n_edit, 1'b1);
    cyc(60);
    check(n_edit, 1'b0);
    check(n_addr, 5'h00);
    cyc(700);
    check(n_present[5], 1'b1);
    check(n_present[4], 1'b0);
    node_cmd(1'b1);
    check(n_code, group_pkg::CODE_NONE);
    wait_run(1'b1, 1'b1);
    check(p_running, 1'b1);
    peer_cmd(1'b0);
    wait_run(1'b0, 1'b0);
    check(n_code, group_pkg::CODE_STOP);
    peer_cmd(1'b1);
    wait_run(1'b0, 1'b1);
    check(n_running, 1'b1);
    @(posedge ref_clk_in);
    fitted <= 1'b1;
    contact_assign <= 1'b1;
    contact <= 1'b0;
    wait_run(1'b0, 1'b0);
    check(n_code, group_pkg::CODE_INPUT_STOP);
    wait_run(1'b1, 1'b0);
    check(p_gstop, 1'b1);
    peer_cmd(1'b1);
    cyc(150);
    check(p_running, 1'b0);
    check(n_running, 1'b0);
    node_cmd(1'b0);
    check(n_code, group_pkg::CODE_STOP);
    @(posedge ref_clk_in);
    contact <= 1'b1;
    wait_run(1'b0, 1'b1);
    check(n_code, group_pkg::CODE_NONE);
    wait_run(1'b1, 1'b1);
    check(p_running, 1'b1);
    node_cmd(1'b0);
    check(n_code, group_pkg::CODE_KEY_STOP);
    wait_run(1'b1, 1'b0);
    check(p_running, 1'b0);
    @(posedge ref_clk_in);
    fitted <= 1'b0;
    contact <= 1'b0;
    node_cmd(1'b1);
    check(n_running, 1'b1);
    wait_run(1'b1, 1'b1);
    @(posedge ref_clk_in);
    p_group <= 5'h04;
    peer_cmd(1'b0);
    cyc(150);
    check(n_running, 1'b1);
    @(posedge ref_clk_in);
    protocol <= 4'h1;
    p_group <= 5'h03;
    node_cmd(1'b0);
    peer_cmd(1'b1);
    cyc(150);
    check(n_running, 1'b0);
    @(posedge ref_clk_in);
    protocol <= 4'h2;
    do_reset();
    check(n_group, 5'h00);
    check(n_present, 32'h00000000);
    cyc(50);
    end_sim();
  end
endmodule

/* src/group_link_if.sv */
// shared multi-drop link between two controller ends
`timescale 1ns/1ps
interface group_link_if;
  logic [group_pkg::FRAME_W-1:0] dev_data;
  logic dev_oe_n;
  logic [group_pkg::FRAME_W-1:0] peer_data;
  logic peer_oe_n;
  wire [group_pkg::FRAME_W-1:0] line =
    (dev_oe_n ? '0 : dev_data) | (peer_oe_n ? '0 : peer_data);
  modport device (output dev_data, output dev_oe_n, input line);
  modport peer (output peer_data, output peer_oe_n, input line);
endinterface

/* src/group_node.sv */
// controller end: group run/stop with contact input and setting editor
//
// Implementation choices: the edit key/set port and the slot and edit cycle counts.
`timescale 1ns/1ps
module group_node #(
  parameter logic [21:0] SLOT_P = 22'(group_pkg::SLOT_CYCLES),
  parameter logic [31:0] EDIT_P = 32'(group_pkg::EDIT_CYCLES)
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  group_link_if.device link,
  input wire logic [3:0] protocol_in,
  input wire logic contact_fitted_in,
  input wire logic contact_assign_in,
  input wire logic contact_input_in,
  input wire logic run_req_in,
  input wire logic stop_req_in,
  input wire logic edit_key_in,
  input wire logic edit_target_in,
  input wire logic [4:0] edit_value_in,
  input wire logic edit_set_in,
  output logic running_out,
  output group_pkg::stop_code_type stop_code_out,
  output logic [4:0] dev_addr_out,
  output logic [4:0] group_out,
  output logic editing_out,
  output logic [31:0] present_out
);
  logic [2:0] contact_sync;
  logic contact_closed;
  logic contact_prev;
  logic key_run;
  logic own_seq;
  logic [31:0] peer_seq;
  logic [31:0] peer_di;
  logic [21:0] slot_cnt;
  logic [4:0] slot_addr;
  group_pkg::link_state_type link_state;
  logic [4:0] pending;
  logic edit_tgt;
  logic [31:0] edit_cnt;

  // speed, format and interval settings have no effect here
  wire link_on = protocol_in == group_pkg::PROTO_LINK;
  wire contact_ctrl = contact_fitted_in & contact_assign_in;
  wire local_di_stop = contact_ctrl & ~contact_closed;
  wire contact_run_evt = contact_ctrl & contact_closed & ~contact_prev;
  wire grouped = link_on & (group_out != group_pkg::GROUP_RESET);

  wire [13:0] rx = link.line;
  wire rx_valid = rx[group_pkg::F_VALID];
  wire [4:0] rx_addr = rx[group_pkg::F_ADDR +: group_pkg::ADDR_W];
  wire [4:0] rx_group = rx[group_pkg::F_GROUP +: group_pkg::GROUP_W];
  wire rx_run = rx[group_pkg::F_RUN];
  wire rx_seq = rx[group_pkg::F_SEQ];
  wire rx_di = rx[group_pkg::F_DI];
  wire slot_end = slot_cnt == SLOT_P - 22'h1;
  wire rotating = link_state == group_pkg::LINK_ROTATE;
  wire rx_take = link_on & slot_end & rx_valid & (rx_addr != dev_addr_out);
  wire rx_member = grouped & (rx_group == group_out);
  // seq learned silently during discovery, no spurious event at power-on
  wire rx_new = rx_take & rotating & rx_member & (rx_seq != peer_seq[rx_addr]);
  wire local_evt = run_req_in | stop_req_in | contact_run_evt;

  // stop from anywhere in the group wins over any run
  wire stop_evt = stop_req_in | (rx_new & ~rx_run);
  wire run_evt = run_req_in | contact_run_evt | (rx_new & rx_run);
  wire next_key_run = stop_evt ? 1'b0 : (run_evt ? 1'b1 : key_run);
  wire group_di_stop = grouped & (|peer_di);
  wire next_running = key_run & ~local_di_stop & ~group_di_stop;
  group_pkg::stop_code_type next_code;
  always_comb
  begin
    if (next_running)
      next_code = group_pkg::CODE_NONE;
    else if (!contact_ctrl)
      next_code = group_pkg::CODE_STOP;
    else if (!key_run)
      next_code = contact_closed ? group_pkg::CODE_KEY_STOP
                                 : group_pkg::CODE_STOP;
    else if (local_di_stop)
      next_code = group_pkg::CODE_INPUT_STOP;
    else
      next_code = group_pkg::CODE_GROUP_STOP;
  end

  wire [31:0] own_bit = 32'h1 << dev_addr_out;
  wire [31:0] next_present_mask = present_out | own_bit;
  wire own_slot = slot_addr == dev_addr_out;
  // mode and frame taken at slot start only, so no frame is cut or altered
  wire tx_load = link_on & own_slot & (slot_cnt == 22'h0);
  wire [13:0] frame = {1'b1, dev_addr_out, group_out, key_run, own_seq,
                       local_di_stop};

  // three-stage sampler, level accepted once stages two and three agree
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      contact_sync <= 3'h7;
      contact_closed <= 1'b1;
      contact_prev <= 1'b1;
    end
    else
    begin
      contact_sync <= {contact_sync[1:0], contact_input_in};
      if (contact_sync[2] == contact_sync[1])
        contact_closed <= contact_sync[2];
      contact_prev <= contact_closed;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key_run <= 1'b0;
      own_seq <= 1'b0;
      running_out <= 1'b0;
      stop_code_out <= group_pkg::CODE_STOP;
    end
    else
    begin
      key_run <= next_key_run;
      if (local_evt)
        own_seq <= ~own_seq;
      running_out <= next_running;
      stop_code_out <= next_code;
    end
  end

  // peers remember their last seq and whether their contact holds stop
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      peer_seq <= 32'h0;
      peer_di <= 32'h0;
    end
    else if (rx_take)
    begin
      peer_seq[rx_addr] <= rx_seq;
      peer_di[rx_addr] <= rx_member & rx_di;
    end
  end

  // one slot per node, so lag is one slot times node count
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slot_cnt <= 22'h0;
      slot_addr <= group_pkg::ADDR_RESET;
      link_state <= group_pkg::LINK_DISCOVER;
      present_out <= 32'h0;
    end
    else
    begin
      slot_cnt <= slot_end ? 22'h0 : slot_cnt + 22'h1;
      if (slot_end)
      begin
        case (link_state)
          group_pkg::LINK_DISCOVER:
          begin
            // the only time peers are learned
            if (rx_take)
              present_out <= next_present_mask | (32'h1 << rx_addr);
            else
              present_out <= next_present_mask;
            if (slot_addr == group_pkg::ADDR_LAST)
            begin
              link_state <= group_pkg::LINK_ROTATE;
              slot_addr <= group_pkg::next_present(next_present_mask,
                                                   group_pkg::ADDR_LAST);
            end
            else
              slot_addr <= slot_addr + 5'h1;
          end
          group_pkg::LINK_ROTATE:
            slot_addr <= group_pkg::next_present(present_out, slot_addr);
          default:
            link_state <= group_pkg::LINK_DISCOVER;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link.dev_data <= 14'h0;
      link.dev_oe_n <= 1'b1;
    end
    else if (tx_load)
    begin
      link.dev_data <= frame;
      link.dev_oe_n <= 1'b0;
    end
    else if (!own_slot)
    begin
      link.dev_data <= 14'h0;
      link.dev_oe_n <= 1'b1;
    end
  end

  // edit is held pending until set; idle for a minute throws it away
  wire edit_timeout = editing_out & (edit_cnt == EDIT_P - 32'h1);
  wire group_ok = pending <= group_pkg::GROUP_MAX;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      editing_out <= 1'b0;
      pending <= 5'h0;
      edit_tgt <= 1'b0;
      edit_cnt <= 32'h0;
      dev_addr_out <= group_pkg::ADDR_RESET;
      group_out <= group_pkg::GROUP_RESET;
    end
    else if (edit_key_in)
    begin
      editing_out <= 1'b1;
      pending <= edit_value_in;
      edit_tgt <= edit_target_in;
      edit_cnt <= 32'h0;
    end
    else if (edit_set_in && editing_out)
    begin
      editing_out <= 1'b0;
      if (edit_tgt)
        dev_addr_out <= pending;
      else if (group_ok)
        group_out <= pending;
    end
    else if (edit_timeout)
      editing_out <= 1'b0;
    else if (editing_out)
      edit_cnt <= edit_cnt + 32'h1;
  end
endmodule

/* src/group_peer.sv */
// far end: a further controller on the same link, keys only
`timescale 1ns/1ps
module group_peer #(
  parameter logic [21:0] SLOT_P = 22'(group_pkg::SLOT_CYCLES)
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  group_link_if.peer link,
  input wire logic [4:0] addr_in,
  input wire logic [4:0] group_in,
  input wire logic run_req_in,
  input wire logic stop_req_in,
  output logic running_out,
  output logic group_stop_out
);
  logic key_run;
  logic own_seq;
  logic [31:0] peer_seq;
  logic [31:0] peer_di;
  logic [31:0] present;
  logic [21:0] slot_cnt;
  logic [4:0] slot_addr;
  group_pkg::link_state_type link_state;

  wire [13:0] rx = link.line;
  wire [4:0] rx_addr = rx[group_pkg::F_ADDR +: group_pkg::ADDR_W];
  wire [4:0] rx_group = rx[group_pkg::F_GROUP +: group_pkg::GROUP_W];
  wire slot_end = slot_cnt == SLOT_P - 22'h1;
  wire rotating = link_state == group_pkg::LINK_ROTATE;
  wire grouped = group_in != group_pkg::GROUP_RESET;
  wire rx_take = slot_end & rx[group_pkg::F_VALID] & (rx_addr != addr_in);
  wire rx_member = grouped & (rx_group == group_in);
  wire rx_new = rx_take & rotating & rx_member
              & (rx[group_pkg::F_SEQ] != peer_seq[rx_addr]);
  wire stop_evt = stop_req_in | (rx_new & ~rx[group_pkg::F_RUN]);
  wire run_evt = run_req_in | (rx_new & rx[group_pkg::F_RUN]);
  wire group_di_stop = grouped & (|peer_di);
  wire [31:0] next_mask = present | (32'h1 << addr_in);
  wire tx_slot = slot_addr == addr_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key_run <= 1'b0;
      own_seq <= 1'b0;
      running_out <= 1'b0;
      group_stop_out <= 1'b0;
      peer_seq <= 32'h0;
      peer_di <= 32'h0;
    end
    else
    begin
      key_run <= stop_evt ? 1'b0 : (run_evt ? 1'b1 : key_run);
      if (run_req_in | stop_req_in)
        own_seq <= ~own_seq;
      running_out <= key_run & ~group_di_stop;
      group_stop_out <= key_run & group_di_stop;
      if (rx_take)
      begin
        peer_seq[rx_addr] <= rx[group_pkg::F_SEQ];
        peer_di[rx_addr] <= rx_member & rx[group_pkg::F_DI];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slot_cnt <= 22'h0;
      slot_addr <= group_pkg::ADDR_RESET;
      link_state <= group_pkg::LINK_DISCOVER;
      present <= 32'h0;
    end
    else
    begin
      slot_cnt <= slot_end ? 22'h0 : slot_cnt + 22'h1;
      if (slot_end)
      begin
        case (link_state)
          group_pkg::LINK_DISCOVER:
          begin
            present <= rx_take ? next_mask | (32'h1 << rx_addr)
                               : next_mask;
            if (slot_addr == group_pkg::ADDR_LAST)
            begin
              link_state <= group_pkg::LINK_ROTATE;
              slot_addr <= group_pkg::next_present(next_mask,
                                                   group_pkg::ADDR_LAST);
            end
            else
              slot_addr <= slot_addr + 5'h1;
          end
          group_pkg::LINK_ROTATE:
            slot_addr <= group_pkg::next_present(present, slot_addr);
          default:
            link_state <= group_pkg::LINK_DISCOVER;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link.peer_data <= 14'h0;
      link.peer_oe_n <= 1'b1;
    end
    else
    begin
      link.peer_data <= tx_slot ? {1'b1, addr_in, group_in, key_run,
                                   own_seq, 1'b0} : 14'h0;
      link.peer_oe_n <= ~tx_slot;
    end
  end
endmodule

/* src/group_pkg.sv */
// constants, types and helpers shared by the group run/stop link ends
package group_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int SLOT_MS = 70;
  localparam int SLOT_CYCLES = CLK_HZ / 1000 * SLOT_MS;
  localparam int SLOT_W = 22;
  localparam int EDIT_S = 60;
  localparam longint EDIT_CYCLES = longint'(CLK_HZ) * EDIT_S;
  localparam int MAX_NODES = 32;
  localparam int ADDR_W = 5;
  localparam int GROUP_W = 5;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic [4:0] ADDR_LAST = 5'h1F;
  localparam logic [4:0] GROUP_RESET = 5'h00;
  localparam logic [4:0] GROUP_MAX = 5'h10;
  localparam int PROTO_W = 4;
  localparam logic [3:0] PROTO_LINK = 4'h2;
  localparam int FRAME_W = 14;
  localparam int F_VALID = 13;
  localparam int F_ADDR = 8;
  localparam int F_GROUP = 3;
  localparam int F_RUN = 2;
  localparam int F_SEQ = 1;
  localparam int F_DI = 0;

  typedef enum logic [2:0] {
    CODE_NONE,
    CODE_STOP,
    CODE_KEY_STOP,
    CODE_INPUT_STOP,
    CODE_GROUP_STOP
  } stop_code_type;

  typedef enum logic {
    LINK_DISCOVER,
    LINK_ROTATE
  } link_state_type;

  // next present address after cur, wrapping
  function automatic logic [4:0] next_present(
    input logic [31:0] mask,
    input logic [4:0] cur
  );
    logic [4:0] idx;
    logic found;
    next_present = cur;
    found = 1'b0;
    for (int i = 1; i <= MAX_NODES; i++)
    begin
      idx = 5'(cur + 5'(i));
      if (!found && mask[idx])
      begin
        next_present = idx;
        found = 1'b1;
      end
    end
  endfunction
endpackage
